// *** verilog/rtlc_pkg.sv ***
// package: constants and carriers for the reset timeout and latch control block
package rtlc_pkg;
   // block clock
   localparam longint CLK_HZ              = 64'd40000000;
   localparam longint CLK_PERIOD_NS       = 64'd25;
   // internal timeout with the timing pin tied high
   localparam longint INT_TIMEOUT_MS      = 64'd200;
   localparam longint INT_TIMEOUT_CYC     = INT_TIMEOUT_MS * CLK_HZ / 64'd1000;
   // short timeout with the timing pin floating and no capacitor
   localparam longint OPEN_TIMEOUT_US     = 64'd400;
   localparam longint OPEN_TIMEOUT_CYC    = OPEN_TIMEOUT_US * CLK_HZ / 64'd1000000;
   // capacitor scaling, picofarads per millisecond times ten
   localparam longint CAP_PF_PER_MS_X10   = 64'd1065;
   localparam longint CAP_CYC_PER_MS      = CLK_HZ / 64'd1000;
   // power-up charge of the capacitor by the source current to the exit threshold
   localparam longint CHARGE_NS_PER_PF    = 64'd90;
   // propagation delay from latch release to reset assertion
   localparam longint LATCH_RELEASE_NS    = 64'd1000;
   localparam int     LATCH_RELEASE_CYC   =
      int'((LATCH_RELEASE_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS);
   // widths
   localparam int     CNT_W               = 32;
   localparam int     CAP_W               = 24;

   // timing pin as seen by the block: neither bit set means floating
   typedef struct packed {
      logic drive_high;
      logic drive_low;
   } rtlc_timing_select_pin_s;

   // comparator results, high when above threshold
   typedef struct packed {
      logic primary_supply_sense;
      logic secondary_supply_sense;
      logic adjustable_supply_sense;
      logic early_warning_sense;
   } rtlc_sense_s;

   // open-drain pin: out and output enable
   typedef struct packed {
      logic out;
      logic oe;
   } rtlc_od_pin_s;

   // gray codes along powerup -> counting -> run -> latch -> release delay
   typedef enum logic [2:0] {
      ST_POWERUP = 3'b000,
      ST_COUNT   = 3'b001,
      ST_RUN     = 3'b011,
      ST_LATCH   = 3'b010,
      ST_RELDLY  = 3'b110
   } rtlc_state_e;
endpackage

// *** verilog/rtlc_reset_timeout_latch_control.sv ***
// reset timeout and margining latch control for a triple supply monitor
//
// Functional notes
// - release reset only after all three supplies stay valid a full timeout
// - timing pin tied high selects the internal 200 ms timeout
// - timing pin floating without capacitor gives about 400 us timeout
// - capacitor on timing pin scales timeout at 106.5 pF per ms
// - timing pin held low freezes reset output and ignores supply changes
// - latched released with inputs valid at release keeps reset released
// - latched released with an input invalid asserts reset after release delay
// - latched asserted and valid at release restarts full timeout before release
// - at power-up with capacitor stay latched asserted until capacitor charges
// - reset and early warning outputs only pull low, wired-or capable
module rtlc_reset_timeout_latch_control
   import rtlc_pkg::*;
#(
   parameter longint INT_TIMEOUT_CYC_P  = INT_TIMEOUT_CYC,
   parameter longint OPEN_TIMEOUT_CYC_P = OPEN_TIMEOUT_CYC,
   parameter longint CAP_CYC_PER_MS_P   = CAP_CYC_PER_MS,
   parameter longint CHARGE_NS_PER_PF_P = CHARGE_NS_PER_PF
) (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_n_i,
   input  wire rtlc_sense_s             sense_i,
   input  wire rtlc_timing_select_pin_s timing_select_pin_i,
   input  wire logic [CAP_W-1:0]        timing_capacitor_pf_i,
   output logic                         system_reset_n_out_o,
   output logic                         system_reset_n_oe_o,
   output logic                         early_warning_out_n_out_o,
   output logic                         early_warning_out_n_oe_o
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // cycles of external timeout for a capacitor value
   function automatic logic [CNT_W-1:0] cap_cycles(input logic [CAP_W-1:0] pf);
      longint c;
      c = longint'(pf) * CAP_CYC_PER_MS_P * 64'd10 / CAP_PF_PER_MS_X10;
      if (c < 64'd1) c = 64'd1;
      return CNT_W'(c);
   endfunction

   // cycles for the source current to charge the capacitor to the exit threshold
   function automatic logic [CNT_W-1:0] charge_cycles(input logic [CAP_W-1:0] pf);
      longint c;
      c = (longint'(pf) * CHARGE_NS_PER_PF_P + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
      if (c < 64'd1) c = 64'd1;
      return CNT_W'(c);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers

   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic [5:0] sync_raw;

   assign sync_raw = {sense_i, timing_select_pin_i};

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else begin
         sync1_q <= sync_raw;
         sync2_q <= sync1_q;
      end
   end

   rtlc_sense_s             sense_s;
   rtlc_timing_select_pin_s tsel_s;
   logic                    all_valid;
   logic                    tmr_low;
   logic                    tmr_high;
   logic                    cap_fitted;

   // only the second flop is looked at; the first may be metastable
   assign sense_s    = rtlc_sense_s'(sync2_q[5:2]);
   assign tsel_s     = rtlc_timing_select_pin_s'(sync2_q[1:0]);
   assign all_valid  = sense_s.primary_supply_sense & sense_s.secondary_supply_sense
                       & sense_s.adjustable_supply_sense;
   assign tmr_low    = tsel_s.drive_low;
   assign tmr_high   = tsel_s.drive_high & ~tsel_s.drive_low;
   assign cap_fitted = (timing_capacitor_pf_i != '0);

   ////////////////////////////////////////////////////////////////////////////
   // timeout selection, registered to keep the divider off the counter path

   logic [CNT_W-1:0] tmo_q;
   logic [CNT_W-1:0] tmo_d;

   always_comb begin
      if (tmr_high) begin
         tmo_d = CNT_W'(INT_TIMEOUT_CYC_P);
      end else if (cap_fitted) begin
         tmo_d = cap_cycles(timing_capacitor_pf_i);
      end else begin
         tmo_d = CNT_W'(OPEN_TIMEOUT_CYC_P);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) tmo_q <= CNT_W'(OPEN_TIMEOUT_CYC_P);
      else          tmo_q <= tmo_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset state machine

   rtlc_state_e      st_q;
   rtlc_state_e      st_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             lat_asserted_q;
   logic             lat_asserted_d;
   logic             rst_assert_d;

   always_comb begin
      st_d           = st_q;
      cnt_d          = cnt_q;
      lat_asserted_d = lat_asserted_q;
      case (st_q)
         ST_POWERUP: begin
            if (!cap_fitted || tmr_high) begin
               st_d  = ST_COUNT;
               cnt_d = '0;
            end else if (cnt_q >= charge_cycles(timing_capacitor_pf_i) - CNT_W'(1)) begin
               st_d  = ST_COUNT;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         ST_COUNT: begin
            if (tmr_low) begin
               st_d           = ST_LATCH;
               lat_asserted_d = 1'b1;
            // continuous validity restarts count on any dip
            end else if (!all_valid) begin
               cnt_d = '0;
            end else if (cnt_q >= tmo_q - CNT_W'(1)) begin
               st_d  = ST_RUN;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         ST_RUN: begin
            if (tmr_low) begin
               st_d           = ST_LATCH;
               lat_asserted_d = 1'b0;
            end else if (!all_valid) begin
               st_d  = ST_COUNT;
               cnt_d = '0;
            end
         end
         ST_LATCH: begin
            if (!tmr_low) begin
               cnt_d = '0;
               if (lat_asserted_q) begin
                  st_d = ST_COUNT;
               end else if (all_valid) begin
                  st_d = ST_RUN;
               end else begin
                  st_d = ST_RELDLY;
               end
            end
         end
         ST_RELDLY: begin
            if (tmr_low) begin
               st_d           = ST_LATCH;
               lat_asserted_d = 1'b0;
            end else if (cnt_q >= CNT_W'(LATCH_RELEASE_CYC - 1)) begin
               st_d  = ST_COUNT;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         default: begin
            st_d  = ST_POWERUP;
            cnt_d = '0;
         end
      endcase
      // reset is asserted in every state except run and the release delay
      // and when latched from a released state
      rst_assert_d = (st_d == ST_POWERUP) || (st_d == ST_COUNT)
                     || ((st_d == ST_LATCH) && lat_asserted_d);
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q           <= ST_POWERUP;
         cnt_q          <= '0;
         lat_asserted_q <= 1'b1;
      end else begin
         st_q           <= st_d;
         cnt_q          <= cnt_d;
         lat_asserted_q <= lat_asserted_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // open-drain outputs: level is always low, only the enable moves

   rtlc_od_pin_s rst_pin_q;
   rtlc_od_pin_s rst_pin_d;
   rtlc_od_pin_s ew_pin_q;
   rtlc_od_pin_s ew_pin_d;

   always_comb begin
      rst_pin_d = '{out: 1'b0, oe: rst_assert_d};
      ew_pin_d  = '{out: 1'b0, oe: ~sense_s.early_warning_sense};
   end

   // reset drives low from the moment of reset; the line pulls up outside
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_pin_q <= '{out: 1'b0, oe: 1'b1};
         ew_pin_q  <= '{out: 1'b0, oe: 1'b1};
      end else begin
         rst_pin_q <= rst_pin_d;
         ew_pin_q  <= ew_pin_d;
      end
   end

   assign system_reset_n_out_o      = rst_pin_q.out;
   assign system_reset_n_oe_o       = rst_pin_q.oe;
   assign early_warning_out_n_out_o = ew_pin_q.out;
   assign early_warning_out_n_oe_o  = ew_pin_q.oe;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   sequence s_count_done;
      st_q == ST_COUNT && all_valid && !tmr_low && cnt_q >= tmo_q - CNT_W'(1);
   endsequence

   property p_release_after_timeout;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_q == ST_RUN && $past(st_q) == ST_COUNT) |-> $past(all_valid)
         && $past(cnt_q) >= $past(tmo_q) - CNT_W'(1);
   endproperty
   a_release_after_timeout: assert property (p_release_after_timeout)
      else $error("reset released before full timeout");

   property p_done_releases;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_count_done |=> st_q == ST_RUN && !system_reset_n_oe_o;
   endproperty
   a_done_releases: assert property (p_done_releases)
      else $error("reset not released after timeout");

   property p_int_timeout;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      tmr_high |=> tmo_q == CNT_W'(INT_TIMEOUT_CYC_P);
   endproperty
   a_int_timeout: assert property (p_int_timeout)
      else $error("internal timeout not selected");

   property p_open_timeout;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (!tmr_high && !cap_fitted) |=> tmo_q == CNT_W'(OPEN_TIMEOUT_CYC_P);
   endproperty
   a_open_timeout: assert property (p_open_timeout)
      else $error("open pin timeout not selected");

   property p_cap_timeout;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (!tmr_high && cap_fitted) |=> tmo_q == cap_cycles($past(timing_capacitor_pf_i));
   endproperty
   a_cap_timeout: assert property (p_cap_timeout)
      else $error("capacitor timeout not scaled");

   property p_latch_frozen;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_q == ST_LATCH && $past(st_q) == ST_LATCH) |=> $stable(system_reset_n_oe_o);
   endproperty
   a_latch_frozen: assert property (p_latch_frozen)
      else $error("reset output moved while latched");

   property p_keep_released;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_q == ST_LATCH && !lat_asserted_q && !tmr_low && all_valid)
         |=> st_q == ST_RUN && !system_reset_n_oe_o;
   endproperty
   a_keep_released: assert property (p_keep_released)
      else $error("reset asserted after valid latch release");

   property p_release_delay;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_q == ST_LATCH && !lat_asserted_q && !tmr_low && !all_valid)
         |=> st_q == ST_RELDLY && !system_reset_n_oe_o;
   endproperty
   a_release_delay: assert property (p_release_delay)
      else $error("invalid latch release not delayed");

   property p_restart_timeout;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_q == ST_LATCH && lat_asserted_q && !tmr_low)
         |=> st_q == ST_COUNT && cnt_q == '0 && system_reset_n_oe_o;
   endproperty
   a_restart_timeout: assert property (p_restart_timeout)
      else $error("timeout not restarted after latch release");

   property p_powerup_held;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      st_q == ST_POWERUP |=> system_reset_n_oe_o;
   endproperty
   a_powerup_held: assert property (p_powerup_held)
      else $error("reset not held during power-up latch");

   property p_pull_low_only;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !system_reset_n_out_o && !early_warning_out_n_out_o;
   endproperty
   a_pull_low_only: assert property (p_pull_low_only)
      else $error("open-drain output driven high");

   property p_sync_depth;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      $changed(sense_i.early_warning_sense) ##2 $stable(sense_i.early_warning_sense)
         |=> early_warning_out_n_oe_o == !$past(sense_i.early_warning_sense, 3);
   endproperty
   a_sync_depth: assert property (p_sync_depth)
      else $error("early warning output not synchronised");
endmodule

// *** tb/rtlc_sys_partner.sv ***
// partner model: margining controller on the timing pin and the pulled-up reset line
module rtlc_sys_partner
   import rtlc_pkg::*;
(
   input  wire logic                    ref_clk_i,
   input  wire logic [1:0]              pin_cmd_i,
   input  wire logic                    rst_out_i,
   input  wire logic                    rst_oe_i,
   output rtlc_timing_select_pin_s      timing_select_pin_o,
   output logic                         rst_line_n_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // legal pin levels
   // 0 floats, 1 ties high, 2 pulls low; both drive bits are never set together
   assign timing_select_pin_o = {pin_cmd_i == 2'h1, pin_cmd_i == 2'h2};

   // wired-or line
   // the weak pull-up wins only while no source pulls the line down
   assign rst_line_n_o = rst_oe_i ? rst_out_i : 1'b1;
endmodule

// *** tb/tb_reset_timeout_latch_control.sv ***
// self-checking bench for the reset timeout and margining latch block
module tb_reset_timeout_latch_control
   import rtlc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int INT_C = 50;
   localparam int OPEN_C = 20;
   localparam int CPM_C = 107;
   logic                    ref_clk_i = 1'b0;
   logic                    rst_n_i = 1'b0;
   rtlc_sense_s             sense = 4'hf;
   logic [1:0]              pin_cmd = 2'h1;
   logic [CAP_W-1:0]        cap_pf = '0;
   rtlc_timing_select_pin_s pin;
   logic                    rst_out;
   logic                    rst_oe;
   logic                    ew_out;
   logic                    ew_oe;
   logic                    rst_line_n;
   int                      fail_count = 0;
   int                      checks = 0;
   int                      n;
   int                      pf;
   int                      e;

   // 40 MHz block clock
   always #12.5 ref_clk_i = ~ref_clk_i;

   rtlc_reset_timeout_latch_control #(
      .INT_TIMEOUT_CYC_P  (64'd50),
      .OPEN_TIMEOUT_CYC_P (64'd20),
      .CAP_CYC_PER_MS_P   (64'd107),
      .CHARGE_NS_PER_PF_P (64'd25)
   ) DUT (
      .ref_clk_i                 (ref_clk_i),
      .rst_n_i                   (rst_n_i),
      .sense_i                   (sense),
      .timing_select_pin_i       (pin),
      .timing_capacitor_pf_i     (cap_pf),
      .system_reset_n_out_o      (rst_out),
      .system_reset_n_oe_o       (rst_oe),
      .early_warning_out_n_out_o (ew_out),
      .early_warning_out_n_oe_o  (ew_oe)
   );

   rtlc_sys_partner u_partner (
      .ref_clk_i           (ref_clk_i),
      .pin_cmd_i           (pin_cmd),
      .rst_out_i           (rst_out),
      .rst_oe_i            (rst_oe),
      .timing_select_pin_o (pin),
      .rst_line_n_o        (rst_line_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // reference model: expected timeout in cycles from pin mode and capacitor
   function automatic int exp_tmo(input logic [1:0] cmd, input int c);
      if (cmd == 2'h1) return INT_C;
      if (c == 0) return OPEN_C;
      return (c * CPM_C * 10 / 1065 > 0) ? c * CPM_C * 10 / 1065 : 1;
   endfunction

   // compare a sampled level
   task automatic chk_lvl(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // compare a duration; pipeline latency allows a few cycles over the minimum
   task automatic chk_dur(input int got, input int lo);
      checks++;
      if (got < lo || got > lo + 8) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask

   // verdict and end of run
   task automatic results();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // bounded wait for the reset line to reach a level, cycles counted
   task automatic wait_line(input logic lvl, input int lim, output int cyc);
      cyc = 0;
      while (rst_line_n !== lvl) begin
         @(negedge ref_clk_i);
         cyc++;
         if (cyc > lim) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, rst_line_n, lvl);
            results();
         end
      end
   endtask

   // the line must hold one level for a number of cycles
   task automatic hold(input logic lvl, input int cyc);
      repeat (cyc) begin
         @(negedge ref_clk_i);
         chk_lvl(rst_line_n, lvl);
      end
   endtask

   task automatic do_reset(input logic [1:0] cmd, input int c);
      rst_n_i <= 1'b0;
      pin_cmd <= cmd;
      cap_pf <= c[CAP_W-1:0];
      sense <= 4'hf;
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hed7b));
      do_reset(2'h1, 0);
      wait_line(1'b1, INT_C + 20, n);
      chk_dur(n, INT_C);
      // early warning follows its comparator with no timeout
      @(posedge ref_clk_i);
      sense[0] <= 1'b0;
      repeat (4) @(negedge ref_clk_i);
      chk_lvl(ew_oe, 1'b1);
      chk_lvl(ew_out | rst_out, 1'b0);
      sense[0] <= 1'b1;
      // each supply in each timing mode, with a glitch that restarts the count
      for (int m = 0; m < 3; m++) begin
         for (int s = 1; s < 4; s++) begin
            pf = (m == 1) ? 1 + $urandom % 150 : 0;
            e = exp_tmo((m == 2) ? 2'h1 : 2'h0, pf);
            @(posedge ref_clk_i);
            pin_cmd <= (m == 2) ? 2'h1 : 2'h0;
            cap_pf <= pf[CAP_W-1:0];
            sense[s] <= 1'b0;
            wait_line(1'b0, 8, n);
            chk_dur(n, 0);
            repeat (e / 2 + 4) @(posedge ref_clk_i);
            sense[s] <= 1'b1;
            repeat (e / 2 + 1) @(posedge ref_clk_i);
            sense[s] <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
            sense[s] <= 1'b1;
            wait_line(1'b1, e + 20, n);
            chk_dur(n, e);
         end
      end
      // margining while released, inputs restored before release
      pin_cmd <= 2'h2;
      hold(1'b1, 4);
      sense[3] <= 1'b0;
      hold(1'b1, 30);
      sense[3] <= 1'b1;
      hold(1'b1, 4);
      pin_cmd <= 2'h1;
      hold(1'b1, 60);
      // margining while released, an input still low at release
      pin_cmd <= 2'h2;
      hold(1'b1, 4);
      sense[2] <= 1'b0;
      hold(1'b1, 10);
      pin_cmd <= 2'h1;
      wait_line(1'b0, LATCH_RELEASE_CYC + 20, n);
      chk_dur(n, LATCH_RELEASE_CYC);
      sense[2] <= 1'b1;
      wait_line(1'b1, INT_C + 20, n);
      chk_dur(n, INT_C);
      // latched in mid-count while asserted; full timeout after release
      sense[1] <= 1'b0;
      wait_line(1'b0, 8, n);
      sense[1] <= 1'b1;
      repeat (INT_C / 2) @(posedge ref_clk_i);
      pin_cmd <= 2'h2;
      hold(1'b0, INT_C + 10);
      pin_cmd <= 2'h1;
      wait_line(1'b1, INT_C + 20, n);
      chk_dur(n, INT_C);
      // power-up with a capacitor: latched until it charges, then the timeout
      do_reset(2'h0, 30);
      wait_line(1'b1, 30 + exp_tmo(2'h0, 30) + 20, n);
      chk_dur(n, 30 + exp_tmo(2'h0, 30));
      results();
   end
endmodule
